// ===== usb_dog_defs.svh
// Offsets, field positions, reset values and timing counts of the USB/watchdog control register
`ifndef USB_DOG_DEFS_SVH
`define USB_DOG_DEFS_SVH

// Register offset on the control interface
`define SYS_CTRL_USB_DOG_ADDR     8'h04

// Field positions
`define USB_LOW_CURRENT_SUSPEND_BIT 15
`define USB_SWITCH_OPEN_BIT         14
`define USB_HOST_ROLE_BIT           13
`define HOST_ROLE_SUPPLY_SELECT_BIT 12
`define HOST_ROLE_HIGH_CURRENT_BIT  11
`define USB_LIMIT_BYPASS_BIT        10
`define DEVICE_ROLE_HIGH_CURRENT_BIT 9
`define DOG_SLEEP_BEHAVIOUR_BIT      7
`define DOG_ACTION_MSB               5
`define DOG_ACTION_LSB               4
`define DOG_PERIOD_MSB               2
`define DOG_PERIOD_LSB               0

// Reset value and field masks
`define SYS_CTRL_USB_DOG_RESET    16'h0004
`define SYS_CTRL_WRITABLE_MASK    16'hfeb7
`define SYS_CTRL_KEYED_MASK       16'h0037
`define SYS_CTRL_SM_RESET_MASK    16'hfa30
`define SYS_CTRL_UVLO_CLEAR_MASK  16'hc200
`define SYS_CTRL_ROLE_DROP_MASK   16'h2000

// Watchdog period codes
`define DOG_PERIOD_LONGEST        3'h5

// Watchdog time base: one step of the period field, in ns
`define DOG_TICK_TIME_NS          125000000
`define SYS_CLK_PERIOD_NS         8
`define DOG_TICK_CYCLES           (`DOG_TICK_TIME_NS / `SYS_CLK_PERIOD_NS)

`endif

// ===== usb_dog_pkg.sv
// Types shared by the USB switch and watchdog control logic
package usb_dog_pkg;

  // Watchdog sequencer, one-hot
  typedef enum logic [2:0] {
    DOG_IDLE     = 3'b001,
    DOG_COUNTING = 3'b010,
    DOG_WARNED   = 3'b100
  } dog_state_t;

  // Watchdog action field encoding
  typedef enum logic [1:0] {
    ACT_OFF       = 2'h0,
    ACT_IRQ       = 2'h1,
    ACT_RESET     = 2'h2,
    ACT_TWO_STAGE = 2'h3
  } dog_action_t;

  // Current limit handed to the analogue switch
  typedef enum logic [1:0] {
    LIMIT_100MA = 2'h0,
    LIMIT_500MA = 2'h1,
    LIMIT_NONE  = 2'h2
  } current_limit_t;

  // Register access from the control interface decoder
  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  // Controls to the USB power switch
  typedef struct packed {
    logic           switch_open;
    logic           low_current_suspend;
    logic           host_role;
    logic           supply_from_line;
    current_limit_t current_limit;
  } usb_ctrl_t;

  // Watchdog events, one-cycle pulses
  typedef struct packed {
    logic expiry_irq;
    logic reset_wake_irq;
    logic system_reset;
  } dog_event_t;

  // Watchdog timer state
  typedef struct packed {
    dog_state_t  state;
    logic [26:0] prescale;
    logic [5:0]  remaining;
    dog_event_t  events;
  } dog_timer_state_t;

  // Control register bank state
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] rd_data;
    logic        rd_valid;
    usb_ctrl_t   usb;
    logic [1:0]  sync1;
    logic [1:0]  sync2;
    logic [1:0]  sync3;
    logic [1:0]  level;
    logic        reload;
  } bank_state_t;

endpackage

// ===== dog_timer.sv
// Watchdog down-counter with single and two-stage time-out actions
`timescale 1ns/1ps
`include "usb_dog_defs.svh"

module dog_timer #(
  parameter int unsigned TICK_CYCLES = `DOG_TICK_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    clk_en_i,
  // Configuration
  input  wire logic                    enable_i,
  input  wire usb_dog_pkg::dog_action_t action_i,
  input  wire logic [2:0]              period_i,
  input  wire logic                    reload_i,
  // Events
  output usb_dog_pkg::dog_event_t      events_o,
  output logic                         running_o
);
  import usb_dog_pkg::*;

  dog_timer_state_t s;
  dog_timer_state_t next_s;
  logic [2:0]       code;
  logic [5:0]       load;
  logic             tick;

  // Reserved long codes run at the longest defined period
  assign code = (period_i > `DOG_PERIOD_LONGEST) ? `DOG_PERIOD_LONGEST
                                                 : period_i; // RQ15
  assign load = 6'h01 << code; // RQ15
  assign tick = (s.prescale == 27'(TICK_CYCLES - 1)); // RQ18

  // Sequencer: count down in ticks, act on reaching zero
  always_comb begin
    next_s        = s;
    next_s.events = '0;
    case (s.state)
      DOG_IDLE: begin
        next_s.prescale  = '0;
        next_s.remaining = load;
        if (enable_i) begin
          next_s.state = DOG_COUNTING;
        end
      end
      DOG_COUNTING, DOG_WARNED: begin
        if (!enable_i) begin
          next_s.state = DOG_IDLE;
        end else if (reload_i) begin
          next_s.prescale  = '0; // RQ14
          next_s.remaining = load; // RQ14
          next_s.state     = DOG_COUNTING; // RQ18
        end else if (tick) begin
          next_s.prescale = '0;
          if (s.remaining == 6'h01) begin
            next_s.remaining = load; // RQ18
            case (action_i)
              ACT_IRQ: begin
                next_s.events.expiry_irq = 1'b1; // RQ10
              end
              ACT_RESET: begin
                next_s.events.reset_wake_irq = 1'b1; // RQ11
                next_s.events.system_reset   = 1'b1; // RQ11
              end
              ACT_TWO_STAGE: begin
                if (s.state == DOG_WARNED) begin
                  next_s.events.reset_wake_irq = 1'b1; // RQ12
                  next_s.events.system_reset   = 1'b1; // RQ12
                  next_s.state                 = DOG_COUNTING;
                end else begin
                  next_s.events.expiry_irq = 1'b1; // RQ12
                  next_s.state             = DOG_WARNED;
                end
              end
              default: begin
                next_s.state = DOG_IDLE; // RQ10
              end
            endcase
          end else begin
            next_s.remaining = s.remaining - 6'h01; // RQ18
          end
        end else begin
          next_s.prescale = s.prescale + 27'h1;
        end
      end
      default: begin
        next_s.state = DOG_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '{state: DOG_IDLE, prescale: 27'h0, remaining: 6'h0,
             events: 3'h0};
    end else if (clk_en_i) begin
      s <= next_s;
    end
  end

  assign events_o  = s.events;
  assign running_o = (s.state != DOG_IDLE);

endmodule

// ===== usb_switch_and_watchdog_ctrl.sv
// USB power switch and watchdog control register with its watchdog
//
// How it works
// RQ1: bit 15 suspends USB with 8mA allowance
// RQ2: bit 14 opens the USB power switch
// RQ3: reset, UVLO, boot fail clear suspend bits
// RQ4: role bit clears on host-to-device drop
// RQ5: host supply from buck two or wall
// RQ6: host role limit 100mA or 500mA
// RQ7: device role limit 100mA or 500mA
// RQ8: bypass bit removes all USB limiting
// RQ9: hibernate stops watchdog unless behaviour set
// RQ10: action 00 disables, 01 raises expiry interrupt
// RQ11: action 10 interrupts and resets the system
// RQ12: action 11 warns first, resets second
// RQ13: action and period writable only unlocked
// RQ14: alive edge or write reloads the timer
// RQ15: period code doubles from 0.125s to 4s
// RQ16: period field bits 2:0, reset 100
// RQ17: deep sleep request selects hibernate state
// RQ18: count down on fixed tick, reload clears warning
`timescale 1ns/1ps
`include "usb_dog_defs.svh"

module usb_switch_and_watchdog_ctrl #(
  parameter int unsigned DOG_TICK_CYCLES = `DOG_TICK_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  clk_en_i,
  // Control interface register port
  input  wire usb_dog_pkg::reg_req_t reg_req_i,
  output logic [15:0]                rd_data_o,
  output logic                       rd_valid_o,
  // System state from the power state machine, same clock
  input  wire logic                  sm_reset_i,
  input  wire logic                  boot_hyst_fail_i,
  input  wire logic                  host_to_device_drop_i,
  input  wire logic                  deep_sleep_request_i,
  input  wire logic                  key_unlocked_i,
  // Asynchronous pins
  input  wire logic                  host_alive_pulse_i,
  input  wire logic                  line_uvlo_i,
  // USB switch controls
  output usb_dog_pkg::usb_ctrl_t     usb_ctrl_o,
  // Watchdog events and status
  output logic                       dog_expiry_irq_o,
  output logic                       dog_reset_wake_irq_o,
  output logic                       system_reset_o,
  output logic                       dog_running_o
);
  import usb_dog_pkg::*;

  localparam int unsigned PIN_ALIVE = 0;
  localparam int unsigned PIN_UVLO  = 1;

  bank_state_t s;
  bank_state_t next_s;
  dog_event_t  dog_events;
  logic        dog_running;

  // Decoded access and conditions
  logic        hit;
  logic        wr_hit;
  logic        rd_hit;
  logic [1:0]  pin_change;
  logic [1:0]  pin_now;
  logic        alive_edge;
  logic        uvlo_active;
  logic        sm_clear;
  logic        hibernate;
  logic        dog_enable;
  logic [15:0] write_mask;
  logic [15:0] written;
  logic [15:0] cleared;
  logic [15:0] ctrl_after;

  // Address decode; only the one register is mapped here
  always_comb begin
    hit = 1'b0;
    if (reg_req_i.addr == `SYS_CTRL_USB_DOG_ADDR) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  assign wr_hit = reg_req_i.wr_en & hit;
  assign rd_hit = reg_req_i.rd_en & hit;

  // Pin filter: a change counts once the second and third stages agree
  assign pin_now    = s.sync3;
  assign pin_change = ~(s.sync2 ^ s.sync3) & (s.sync3 ^ s.level);

  // Either edge of the alive pulse retriggers the watchdog
  assign alive_edge  = pin_change[PIN_ALIVE]; // RQ14
  assign uvlo_active = s.level[PIN_UVLO];

  // A watchdog system reset acts like a state machine reset here
  assign sm_clear = sm_reset_i | dog_events.system_reset; // RQ13

  // Hibernate follows the deep sleep request bit
  assign hibernate = deep_sleep_request_i; // RQ17

  // Watchdog runs unless disabled by action or by hibernate
  always_comb begin
    dog_enable = 1'b1;
    if (dog_action_t'(s.ctrl[`DOG_ACTION_MSB:`DOG_ACTION_LSB]) == ACT_OFF)
    begin
      dog_enable = 1'b0; // RQ10
    end else if (hibernate && !s.ctrl[`DOG_SLEEP_BEHAVIOUR_BIT]) begin
      dog_enable = 1'b0; // RQ9
    end else begin
      dog_enable = 1'b1; // RQ9
    end
  end

  // Keyed fields stay frozen while the security key is locked
  always_comb begin
    write_mask = `SYS_CTRL_WRITABLE_MASK;
    if (!key_unlocked_i) begin
      write_mask = `SYS_CTRL_WRITABLE_MASK & ~`SYS_CTRL_KEYED_MASK; // RQ13
    end
  end

  // Merge the host write into the stored value
  always_comb begin
    written = s.ctrl;
    if (wr_hit) begin
      written = (s.ctrl & ~write_mask) | (reg_req_i.wdata & write_mask);
    end
  end

  // Hardware clears take priority over a write in the same cycle, so a
  // fault or role drop is never masked by a racing host write
  always_comb begin
    cleared = 16'h0000;
    if (sm_clear) begin
      cleared = cleared | `SYS_CTRL_SM_RESET_MASK; // RQ3
    end
    if (uvlo_active || boot_hyst_fail_i) begin
      cleared = cleared | `SYS_CTRL_UVLO_CLEAR_MASK; // RQ3
    end
    if (host_to_device_drop_i) begin
      cleared = cleared | `SYS_CTRL_ROLE_DROP_MASK; // RQ4
    end
  end

  assign ctrl_after = written & ~cleared;

  // Next state of the bank
  always_comb begin
    next_s = s;

    // Synchroniser chain; stage one feeds only stage two
    next_s.sync1 = {line_uvlo_i, host_alive_pulse_i};
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    next_s.level = s.level ^ pin_change;

    // Register contents
    next_s.ctrl = ctrl_after;

    // Reload on a register write or an alive edge
    next_s.reload = wr_hit | alive_edge; // RQ14

    // Read answer, one cycle after the request
    next_s.rd_valid = reg_req_i.rd_en;
    next_s.rd_data  = 16'h0000;
    if (rd_hit) begin
      next_s.rd_data = s.ctrl & `SYS_CTRL_WRITABLE_MASK;
    end

    // Switch controls derived from the new register value
    next_s.usb.low_current_suspend =
      ctrl_after[`USB_LOW_CURRENT_SUSPEND_BIT]; // RQ1
    next_s.usb.switch_open =
      ctrl_after[`USB_SWITCH_OPEN_BIT]; // RQ2
    next_s.usb.host_role =
      ctrl_after[`USB_HOST_ROLE_BIT]; // RQ4
    next_s.usb.supply_from_line =
      ctrl_after[`HOST_ROLE_SUPPLY_SELECT_BIT]; // RQ5

    // Limit selection: bypass first, then the active role's setting
    if (ctrl_after[`USB_LIMIT_BYPASS_BIT]) begin
      next_s.usb.current_limit = LIMIT_NONE; // RQ8
    end else if (ctrl_after[`USB_HOST_ROLE_BIT]) begin
      next_s.usb.current_limit =
        ctrl_after[`HOST_ROLE_HIGH_CURRENT_BIT] ? LIMIT_500MA
                                                : LIMIT_100MA; // RQ6
    end else begin
      next_s.usb.current_limit =
        ctrl_after[`DEVICE_ROLE_HIGH_CURRENT_BIT] ? LIMIT_500MA
                                                  : LIMIT_100MA; // RQ7
    end
  end

  // State register; reset restores the documented defaults
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s.ctrl     <= `SYS_CTRL_USB_DOG_RESET; // RQ16
      s.rd_data  <= 16'h0000;
      s.rd_valid <= 1'b0;
      s.usb      <= '{switch_open: 1'b0, low_current_suspend: 1'b0,
                      host_role: 1'b0, supply_from_line: 1'b0,
                      current_limit: LIMIT_100MA}; // RQ3
      s.sync1    <= 2'h0;
      s.sync2    <= 2'h0;
      s.sync3    <= 2'h0;
      s.level    <= 2'h0;
      s.reload   <= 1'b0;
    end else if (clk_en_i) begin
      s <= next_s;
    end
  end

  // Watchdog counter; the reload is registered so it lines up with the
  // period value that the same write stores
  dog_timer #(
    .TICK_CYCLES (DOG_TICK_CYCLES)
  ) u_dog_timer (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .clk_en_i  (clk_en_i),
    .enable_i  (dog_enable),
    .action_i  (dog_action_t'(s.ctrl[`DOG_ACTION_MSB:`DOG_ACTION_LSB])),
    .period_i  (s.ctrl[`DOG_PERIOD_MSB:`DOG_PERIOD_LSB]),
    .reload_i  (s.reload),
    .events_o  (dog_events),
    .running_o (dog_running)
  );

  // Outputs, all from flip-flops
  assign rd_data_o            = s.rd_data;
  assign rd_valid_o           = s.rd_valid;
  assign usb_ctrl_o           = s.usb;
  assign dog_expiry_irq_o     = dog_events.expiry_irq;
  assign dog_reset_wake_irq_o = dog_events.reset_wake_irq;
  assign system_reset_o       = dog_events.system_reset;
  assign dog_running_o        = dog_running;

  // Pin level kept for completeness of the filter path
  logic unused_pin_now;
  assign unused_pin_now = ^pin_now;

endmodule

// ===== usb_dog_props.sv
// Port assertions for the USB switch and watchdog control register
`timescale 1ns/1ps
module usb_dog_props (
  // Clock, reset and requests
  input wire logic                   sys_clk_i,
  input wire logic                   rst_n_i,
  input wire logic                   clk_en_i,
  input wire usb_dog_pkg::reg_req_t  reg_req_i,
  // Hardware clear causes
  input wire logic                   sm_reset_i,
  input wire logic                   boot_hyst_fail_i,
  input wire logic                   host_to_device_drop_i,
  input wire logic                   line_uvlo_i,
  // Observed outputs
  input wire logic                   rd_valid_o,
  input wire usb_dog_pkg::usb_ctrl_t usb_ctrl_o,
  input wire logic                   dog_expiry_irq_o,
  input wire logic                   dog_reset_wake_irq_o,
  input wire logic                   system_reset_o
);
  import usb_dog_pkg::*;
  logic [2:0]  quiet;
  logic [15:0] w_d;
  logic        sr_d;
  logic        hit;
  usb_ctrl_t   u;

  // A write no hardware clear can beat; the supply pin is seen late
  assign u = usb_ctrl_o;
  assign hit = reg_req_i.wr_en && clk_en_i && reg_req_i.addr == 8'h04 &&
    !sm_reset_i && !boot_hyst_fail_i && !host_to_device_drop_i &&
    quiet == 3'h7 && !system_reset_o && !sr_d;

  // Quiet time after undervoltage, last write data, last system reset
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      quiet <= 3'h0;
      w_d   <= 16'h0000;
      sr_d  <= 1'b0;
    end else begin
      quiet <= line_uvlo_i ? 3'h0 : (quiet == 3'h7 ? quiet : quiet + 3'h1);
      w_d   <= reg_req_i.wdata;
      sr_d  <= system_reset_o;
    end
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_read; reg_req_i.rd_en && clk_en_i |=> rd_valid_o; endproperty
  a_read: assert property (p_read) else $error("read not answered");
  property p_bits; hit |=> {u.switch_open, u.low_current_suspend,
    u.supply_from_line} == {w_d[14], w_d[15], w_d[12]}; endproperty
  a_bits: assert property (p_bits) else $error("switch bits");
  property p_limit; hit |=> u.current_limit == (w_d[10] ? LIMIT_NONE :
    (w_d[13] ? w_d[11] : w_d[9]) ? LIMIT_500MA : LIMIT_100MA); endproperty
  a_limit: assert property (p_limit) else $error("limit");
  property p_role; hit |=> u.host_role == w_d[13]; endproperty
  a_role: assert property (p_role) else $error("role write");
  property p_drop; host_to_device_drop_i && clk_en_i |=> !u.host_role;
  endproperty
  a_drop: assert property (p_drop) else $error("role drop");
  property p_boot; boot_hyst_fail_i && clk_en_i |=>
    !u.switch_open && !u.low_current_suspend; endproperty
  a_boot: assert property (p_boot) else $error("boot clear");
  property p_uvlo; (line_uvlo_i && clk_en_i)[*6] |=>
    !u.switch_open && !u.low_current_suspend; endproperty
  a_uvlo: assert property (p_uvlo) else $error("uvlo clear");
  property p_sm; sm_reset_i && clk_en_i |=>
    !u.host_role && !u.supply_from_line && !u.switch_open; endproperty
  a_sm: assert property (p_sm) else $error("sm clear");
  property p_pair; system_reset_o |->
    dog_reset_wake_irq_o && !dog_expiry_irq_o; endproperty
  a_pair: assert property (p_pair) else $error("reset pair");
  property p_pulse; dog_expiry_irq_o |=>
    !dog_expiry_irq_o && !system_reset_o; endproperty
  a_pulse: assert property (p_pulse) else $error("expiry pulse");

  c_expiry: cover property (dog_expiry_irq_o);
  c_reset: cover property (system_reset_o);
  c_uvlo: cover property ((line_uvlo_i && clk_en_i)[*6]);
endmodule

bind usb_switch_and_watchdog_ctrl usb_dog_props u_props (.*);

// ===== host_model.sv
// Host processor model: register port accesses and the alive pin
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire logic              sys_clk_i,
  // Register port
  output usb_dog_pkg::reg_req_t  reg_req_o,
  input  wire logic [15:0]       rd_data_i,
  input  wire logic              rd_valid_i,
  // Alive pin
  output logic                   host_alive_pulse_o
);
  import usb_dog_pkg::*;

  // Idle port; released fields show inverted data so stale values fail
  initial begin
    reg_req_o          = '0;
    host_alive_pulse_o = 1'b0;
  end

  // One write, taken at the edge after it is driven
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_req_o <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk_i);
    reg_req_o <= '{1'b0, 1'b0, ~a, ~d};
  endtask

  // One read; data is only trusted while valid stands
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk_i);
    reg_req_o <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge sys_clk_i);
    reg_req_o <= '{1'b0, 1'b0, ~a, 16'hffff};
    #1 d = rd_valid_i ? rd_data_i : 16'hxxxx;
  endtask

  // Either edge of the alive pin retriggers the watchdog
  task automatic beat;
    @(posedge sys_clk_i);
    host_alive_pulse_o <= ~host_alive_pulse_o;
  endtask
endmodule

// ===== usb_switch_and_watchdog_ctrl_test.sv
// Self-checking bench for the USB switch and watchdog control register
`timescale 1ns/1ps
module usb_switch_and_watchdog_ctrl_test;
  import usb_dog_pkg::*;
  localparam int TICK = 4;
  localparam logic [15:0] CLR [4] = '{16'hfa30, 16'hc200, 16'hc200, 16'h2000};
  localparam logic [1:0]  ACTS [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  localparam logic [3:0]  EVS [4] = '{4'b0000, 4'b1010, 4'b1001, 4'b0100};
  logic        sys_clk_i, rst_n_i, clk_en_i, sm_reset_i, boot_hyst_fail_i;
  logic        host_to_device_drop_i, deep_sleep_request_i, key_unlocked_i;
  logic        host_alive_pulse_i, line_uvlo_i, rd_valid_o, dog_running_o;
  logic        dog_expiry_irq_o, dog_reset_wake_irq_o, system_reset_o;
  logic [15:0] rd_data_o, model, d, w;
  logic [1:0]  ev;
  reg_req_t    reg_req_i;
  usb_ctrl_t   usb_ctrl_o;
  int          errors, checked, t, n;

  usb_switch_and_watchdog_ctrl #(.DOG_TICK_CYCLES(TICK)) dut (.*);
  host_model host (.sys_clk_i(sys_clk_i), .reg_req_o(reg_req_i),
    .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o),
    .host_alive_pulse_o(host_alive_pulse_i));

  // 125 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input string s, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Switch controls expected from a register value
  function automatic usb_ctrl_t exp_usb(input logic [15:0] r);
    exp_usb = '{r[14], r[15], r[13], r[12], r[10] ? LIMIT_NONE :
      (r[13] ? r[11] : r[9]) ? LIMIT_500MA : LIMIT_100MA};
  endfunction

  // Keyed fields hold their old value while the key is locked
  function automatic logic [15:0] exp_wr(input logic [15:0] o, v,
                                         input logic key);
    logic [15:0] k;
    k = key ? 16'h0000 : 16'h0037;
    exp_wr = (v & 16'hfeb7 & ~k) | (o & k);
  endfunction

  // Write, read back and compare register and switch controls
  task automatic wr_chk(input logic [15:0] v);
    if (clk_en_i) model = exp_wr(model, v, key_unlocked_i);
    host.wr(8'h04, v);
    clk_en_i <= 1'b1;
    host.rd(8'h04, d);
    chk("register", d, model);
    chk("switch", {10'h0, usb_ctrl_o}, {10'h0, exp_usb(model)});
  endtask

  // Wait a bounded time for the first watchdog event
  task automatic wait_ev(input int lim);
    ev = 2'b00;
    for (t = 0; t < lim && ev == 2'b00; t++) begin
      @(posedge sys_clk_i);
      #1 ev = {dog_expiry_irq_o, dog_reset_wake_irq_o};
    end
  endtask

  // Start a watchdog setting from a quiet, freshly reloaded state
  task automatic dog_set(input logic [15:0] v);
    host.wr(8'h04, 16'h0000);
    repeat (20) @(posedge sys_clk_i);
    host.wr(8'h04, v);
  endtask

  // Hang guard, far beyond the few thousand cycles the tests need
  initial begin
    #400000;
    errors++;
    $display("watchdog expired before the end");
    finish_test;
  end

  initial begin
    {rst_n_i, sm_reset_i, boot_hyst_fail_i, host_to_device_drop_i} = 4'h0;
    {deep_sleep_request_i, line_uvlo_i} = 2'h0;
    clk_en_i       = 1'b1;
    key_unlocked_i = 1'b1;
    errors         = 0;
    checked        = 0;
    void'($urandom(32'h580b));
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    model = 16'h0004;
    host.rd(8'h04, d);
    chk("reset value", d, 16'h0004);
    chk("reset switch", {10'h0, usb_ctrl_o}, 16'h0000);
    host.wr(8'h05, 16'hffff);
    host.rd(8'h05, d);
    chk("unmapped", d, 16'h0000);
    $display("test reset done");
    // Random writes, action kept off; locked key and frozen clock mixed in
    for (int i = 0; i < 26; i++) begin
      w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
      key_unlocked_i <= 1'($urandom);
      clk_en_i <= ($urandom % 4) != 0;
      @(posedge sys_clk_i);
      wr_chk(w & 16'hffcf);
    end
    key_unlocked_i <= 1'b1;
    $display("test random writes done");
    // Each hardware clear source against a register full but for the action field
    for (int k = 0; k < 4; k++) begin
      wr_chk(16'hfe87);
      @(posedge sys_clk_i);
      case (k)
        0: sm_reset_i <= 1'b1;
        1: boot_hyst_fail_i <= 1'b1;
        2: line_uvlo_i <= 1'b1;
        default: host_to_device_drop_i <= 1'b1;
      endcase
      repeat (8) @(posedge sys_clk_i);
      {sm_reset_i, boot_hyst_fail_i, line_uvlo_i, host_to_device_drop_i} <= 0;
      repeat (8) @(posedge sys_clk_i);
      model &= ~CLR[k];
      host.rd(8'h04, d);
      chk("clear", d, model);
    end
    $display("test clears done");
    // All action codes, two event waits each, shortest period; action 00 gives no event, action 10 only one
    for (int k = 0; k < 4; k++) begin
      dog_set({10'h0, ACTS[k], 4'h0});
      wait_ev(60);
      chk("first event", {14'h0, ev}, {14'h0, EVS[k][3:2]});
      wait_ev(60);
      chk("second event", {14'h0, ev}, {14'h0, EVS[k][1:0]});
    end
    host.rd(8'h04, d);
    chk("action after reset", d, 16'h0000);
    // A write between time-outs restarts the two-stage sequence
    dog_set(16'h0030);
    wait_ev(60);
    host.wr(8'h04, 16'h0030);
    wait_ev(60);
    chk("warning cleared", {14'h0, ev}, 16'h0002);
    wait_ev(60);
    chk("second stage", {14'h0, ev}, 16'h0001);
    $display("test actions done");
    // Hibernate with the watchdog disabled, then kept running
    deep_sleep_request_i <= 1'b1;
    dog_set(16'h0010);
    wait_ev(80);
    chk("sleep off", {14'h0, ev}, 16'h0000);
    chk("sleep idle", {15'h0, dog_running_o}, 16'h0000);
    dog_set(16'h0090);
    wait_ev(80);
    chk("sleep on", {14'h0, ev}, 16'h0002);
    chk("sleep running", {15'h0, dog_running_o}, 16'h0001);
    deep_sleep_request_i <= 1'b0;
    $display("test hibernate done");
    // Alive pulses every 8 cycles hold off a 16 cycle time-out
    dog_set(16'h0012);
    ev = 2'b00;
    repeat (14) begin
      host.beat();
      repeat (7) begin
        @(posedge sys_clk_i);
        #1 ev |= {dog_expiry_irq_o, dog_reset_wake_irq_o};
      end
    end
    chk("alive holds", {14'h0, ev}, 16'h0000);
    wait_ev(60);
    chk("alive stopped", {14'h0, ev}, 16'h0002);
    $display("test reload done");
    // Time-out length per period code, reserved code runs as longest
    for (int c = 0; c < 7; c++) begin
      dog_set({12'h001, 1'b0, 3'(c)});
      wait_ev(300);
      n = (1 << (c > 5 ? 5 : c)) * TICK;
      chk("period", {15'h0, t >= n - TICK && t <= n + TICK + 8}, 16'h1);
    end
    $display("test periods done");
    finish_test;
  end
endmodule
